/* File: rtl/adcsel_pkg.sv */
package adcsel_pkg;

   // ==========================================================
   // register map: printed offsets are indices, byte address = 4 * index
   localparam int          ADDR_W       = 12;
   localparam logic [7:0]  CTRL_IDX     = 8'he8;
   localparam logic [7:0]  SEL_IDX      = 8'hbb;
   localparam logic [7:0]  CFG_IDX      = 8'hbc;
   localparam logic [7:0]  DATA_IDX     = 8'hbf;
   localparam logic [ADDR_W-1:0] CTRL_ADDR = {2'h0, CTRL_IDX, 2'h0};
   localparam logic [ADDR_W-1:0] SEL_ADDR  = {2'h0, SEL_IDX, 2'h0};
   localparam logic [ADDR_W-1:0] CFG_ADDR  = {2'h0, CFG_IDX, 2'h0};
   localparam logic [ADDR_W-1:0] DATA_ADDR = {2'h0, DATA_IDX, 2'h0};

   // ==========================================================
   // reset values
   localparam logic [7:0]  CTRL_RST     = 8'h00;
   localparam logic [7:0]  SEL_RST      = 8'h00;
   localparam logic [7:0]  CFG_RST      = 8'h60;
   localparam logic [7:0]  DATA_RST     = 8'h00;

   // ==========================================================
   // field positions
   localparam int          CTRL_EN_BIT   = 7;
   localparam int          CTRL_TM_BIT   = 6;
   localparam int          CTRL_INT_BIT  = 5;
   localparam int          CTRL_BUSY_BIT = 4;
   localparam int          CTRL_STM_LSB  = 2;
   localparam int          CTRL_WIN_BIT  = 1;
   localparam int          CTRL_LJ_BIT   = 0;
   localparam int          SEL_MUXEN_BIT = 5;
   localparam int          SEL_PRT_LSB   = 3;
   localparam int          SEL_PIN_LSB   = 0;
   localparam int          CFG_SC_LSB    = 5;
   localparam int          CFG_GAIN_LSB  = 0;

   // ==========================================================
   // start modes, gain lines, timing
   localparam logic [1:0]  STM_SW        = 2'h0;
   localparam logic [1:0]  STM_TIMER     = 2'h3;
   localparam int          GAIN_HALF     = 0;
   localparam int          GAIN_X1       = 1;
   localparam int          GAIN_X2       = 2;
   localparam int          GAIN_X4       = 3;
   localparam int          GAIN_X8       = 4;
   localparam int          GAIN_X16      = 5;
   localparam int          GAIN_N        = 6;
   localparam int          RES_W         = 8;
   localparam logic [3:0]  CONV_SAR_CLKS = 4'hb;

   typedef enum logic {ST_IDLE, ST_CONV} adcsel_conv_e;

   typedef struct packed {
      logic              hsel;
      logic [31:0]       haddr;
      logic [1:0]        htrans;
      logic              hwrite;
      logic [2:0]        hsize;
      logic [31:0]       hwdata;
      logic              hready;
   } adcsel_ahb_req_s;

   typedef struct packed {
      logic              hreadyout;
      logic              hresp;
      logic [31:0]       hrdata;
   } adcsel_ahb_rsp_s;

   typedef struct packed {
      logic              en;
      logic              tm;
      logic              int_flag;
      logic [1:0]        stm;
      logic              win;
      logic              ljst;
      logic              mux_en;
      logic [1:0]        prt;
      logic [2:0]        pin;
      logic [2:0]        sc;
      logic [2:0]        gain;
      logic [RES_W-1:0]  data;
      adcsel_conv_e      conv;
      logic [3:0]        div_cnt;
      logic [3:0]        bit_cnt;
      logic [RES_W-1:0]  res_s1;
      logic [RES_W-1:0]  res_s2;
      logic              ap_valid;
      logic              ap_write;
      logic [ADDR_W-1:0] ap_addr;
      logic [31:0]       rdata;
   } adcsel_state_s;

endpackage

/* File: rtl/adcsel_decode.sv */
`timescale 1ns/1ps
module adcsel_decode (
   input  wire logic        mux_en,
   input  wire logic [1:0]  prt,
   input  wire logic [2:0]  pin,
   input  wire logic [2:0]  gain,
   output logic      [31:0] pin_sel,
   output logic      [5:0]  gain_sel
);
   import adcsel_pkg::*;

   // ==========================================================
   // pin routing: one line per port pin, none while the mux is off
   for (genvar i = 0; i < 32; i++) begin : g_pin
      assign pin_sel[i] = mux_en && ({prt, pin} == 5'(i)); // [R7] [R8] [R9] [R4]
   end

   // ==========================================================
   // gain decode
   always_comb begin
      gain_sel = '0;
      case (gain) // [R10] [R5]
         3'h0:        gain_sel[GAIN_X1]   = 1'b1;
         3'h1:        gain_sel[GAIN_X2]   = 1'b1;
         3'h2:        gain_sel[GAIN_X4]   = 1'b1;
         3'h3:        gain_sel[GAIN_X8]   = 1'b1;
         3'h4, 3'h5:  gain_sel[GAIN_X16]  = 1'b1;
         default:     gain_sel[GAIN_HALF] = 1'b1;
      endcase
   end

endmodule

/* File: rtl/adcsel_top.sv */
// Overview of operation
// R1 - conversion results are eight bits wide, latched into the data register
// R2 - converter, track-and-hold and gain stage run only while subsystem enable is 1
// R3 - input select register picks any pin of ports 0 to 3
// R4 - with mux enabled, input comes from selected pin of selected port
// R5 - gain field of config register sets gain: 0.5, 1, 2, 4, 8, 16
// R6 - gain stage resets to gain 1
// R7 - no pin reaches the converter while mux enable is 0
// R8 - port field 00..11 selects port 0..3
// R9 - pin field 000..111 selects pin 0..7 of that port
// R10 - gain code 000=1, 001=2, 010=4, 011=8, 10x=16, 11x=0.5
// R11 - while disabled, starts are ignored and status flags stay unchanged
`timescale 1ns/1ps
module adcsel_top (
   input  wire logic                        clock,
   input  wire logic                        arst_n,
   input  wire adcsel_pkg::adcsel_ahb_req_s ahb_req,
   output adcsel_pkg::adcsel_ahb_rsp_s      ahb_rsp,
   input  wire logic                        timer_ovf,
   input  wire logic [7:0]                  sar_result,
   output logic                             analog_en,
   output logic                             conv_busy,
   output logic [31:0]                      pin_sel,
   output logic [5:0]                       gain_sel
);
   import adcsel_pkg::*;

   adcsel_state_s s_q;
   adcsel_state_s s_d;
   logic          ap_take;
   logic          ctrl_wr;
   logic          sw_start;
   logic          start;
   logic          sar_tick;
   logic [3:0]    div_max;
   logic [7:0]    wb;

   // ==========================================================
   // next state
   always_comb begin
      s_d      = s_q;
      ctrl_wr  = 1'b0;
      sw_start = 1'b0;
      wb       = ahb_req.hwdata[7:0];
      ap_take  = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1];
      // settled analog word; held stable by the front end during a conversion
      s_d.res_s1 = sar_result;
      s_d.res_s2 = s_q.res_s1;

      if (s_q.ap_valid && s_q.ap_write) begin
         case (s_q.ap_addr)
            CTRL_ADDR: begin
               ctrl_wr    = 1'b1;
               s_d.en     = wb[CTRL_EN_BIT]; // [R2]
               s_d.tm     = wb[CTRL_TM_BIT];
               s_d.int_flag = wb[CTRL_INT_BIT];
               s_d.stm    = wb[CTRL_STM_LSB +: 2];
               s_d.win    = wb[CTRL_WIN_BIT];
               s_d.ljst   = wb[CTRL_LJ_BIT];
               sw_start   = wb[CTRL_BUSY_BIT];
            end
            SEL_ADDR: begin
               s_d.mux_en = wb[SEL_MUXEN_BIT]; // [R3]
               s_d.prt    = wb[SEL_PRT_LSB +: 2];
               s_d.pin    = wb[SEL_PIN_LSB +: 3];
            end
            CFG_ADDR: begin
               s_d.sc     = wb[CFG_SC_LSB +: 3];
               s_d.gain   = wb[CFG_GAIN_LSB +: 3]; // [R5]
            end
            DATA_ADDR: s_d.data = wb;
            default: ;
         endcase
      end

      // sar clock: 1, 2, 4, 8 or 16 system clocks
      case (s_q.sc)
         3'h0:    div_max = 4'h0;
         3'h1:    div_max = 4'h1;
         3'h2:    div_max = 4'h3;
         3'h3:    div_max = 4'h7;
         default: div_max = 4'hf;
      endcase
      sar_tick = (s_q.div_cnt == div_max);
      // only the enable held before this write counts, so a start in the
      // same write as the enable is refused
      start = s_q.en && ((sw_start && s_q.stm == STM_SW) ||
                         (timer_ovf && s_q.stm == STM_TIMER)); // [R11]

      if (s_q.en) begin // [R11] [R2]
         case (s_q.conv)
            ST_IDLE: begin
               if (start) begin
                  s_d.conv    = ST_CONV;
                  s_d.div_cnt = '0;
                  s_d.bit_cnt = '0;
               end
            end
            ST_CONV: begin
               s_d.div_cnt = sar_tick ? 4'h0 : s_q.div_cnt + 4'h1;
               if (sar_tick) begin
                  if (s_q.bit_cnt == CONV_SAR_CLKS - 4'h1) begin
                     s_d.conv     = ST_IDLE;
                     s_d.data     = s_q.res_s2; // [R1]
                     s_d.int_flag = 1'b1; // set wins over a same-cycle clear
                  end else begin
                     s_d.bit_cnt = s_q.bit_cnt + 4'h1;
                  end
               end
            end
            default: s_d.conv = ST_IDLE;
         endcase
      end

      // ahb address phase; read data built from post-write values
      s_d.ap_valid = ap_take;
      if (ap_take) begin
         s_d.ap_write = ahb_req.hwrite;
         s_d.ap_addr  = ahb_req.haddr[ADDR_W-1:0];
         if (!ahb_req.hwrite) begin
            case (ahb_req.haddr[ADDR_W-1:0])
               CTRL_ADDR: s_d.rdata = {24'h0, s_d.en, s_d.tm, s_d.int_flag,
                                       (s_d.conv == ST_CONV), s_d.stm, s_d.win, s_d.ljst};
               SEL_ADDR:  s_d.rdata = {26'h0, s_d.mux_en, s_d.prt, s_d.pin};
               CFG_ADDR:  s_d.rdata = {24'h0, s_d.sc, 2'h0, s_d.gain};
               DATA_ADDR: s_d.rdata = {24'h0, s_d.data};
               default:   s_d.rdata = 32'h0;
            endcase
         end
      end
   end

   // ==========================================================
   // state register
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         s_q          <= '0;
         s_q.en       <= CTRL_RST[CTRL_EN_BIT];
         s_q.stm      <= CTRL_RST[CTRL_STM_LSB +: 2];
         s_q.mux_en   <= SEL_RST[SEL_MUXEN_BIT];
         s_q.sc       <= CFG_RST[CFG_SC_LSB +: 3];
         s_q.gain     <= CFG_RST[CFG_GAIN_LSB +: 3]; // [R6]
         s_q.data     <= DATA_RST;
         s_q.conv     <= ST_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // outputs
   assign ahb_rsp.hreadyout = 1'b1;
   assign ahb_rsp.hresp     = 1'b0;
   assign ahb_rsp.hrdata    = s_q.rdata;
   assign analog_en         = s_q.en; // [R2]
   assign conv_busy         = (s_q.conv == ST_CONV);

   adcsel_decode u_decode (
      .mux_en   (s_q.mux_en),
      .prt      (s_q.prt),
      .pin      (s_q.pin),
      .gain     (s_q.gain),
      .pin_sel  (pin_sel),
      .gain_sel (gain_sel)
   );

   // ==========================================================
   // checks
   logic cfg_written_q;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cfg_written_q <= 1'b0;
      end else if (s_q.ap_valid && s_q.ap_write && s_q.ap_addr == CFG_ADDR) begin
         cfg_written_q <= 1'b1;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   sequence sel_write_s;
      ap_take && ahb_req.hwrite && ahb_req.haddr[ADDR_W-1:0] == SEL_ADDR;
   endsequence
   sequence ctrl_write_s;
      ap_take && ahb_req.hwrite && ahb_req.haddr[ADDR_W-1:0] == CTRL_ADDR;
   endsequence
   sequence conv_end_s;
      conv_busy ##1 !conv_busy;
   endsequence

   shutdown_gate_a: assert property (ctrl_write_s ##1 1'b1 |=> // [R2]
      analog_en == $past(ahb_req.hwdata[CTRL_EN_BIT]))
      else $error("analog enable does not follow subsystem enable");
   sel_write_a: assert property (sel_write_s ##1 1'b1 |=> // [R3]
      s_q.mux_en == $past(ahb_req.hwdata[SEL_MUXEN_BIT]) &&
      {s_q.prt, s_q.pin} == $past(ahb_req.hwdata[4:0]))
      else $error("input select write not stored");
   route_pin_a: assert property (s_q.mux_en |-> $onehot(pin_sel) && // [R4]
      pin_sel[{s_q.prt, s_q.pin}])
      else $error("selected pin not routed");
   mux_off_a: assert property (!s_q.mux_en |-> pin_sel == 32'h0) // [R7]
      else $error("pin routed while mux disabled");
   port_dec_a: assert property (s_q.mux_en |-> pin_sel[s_q.prt*8 +: 8] != 8'h0) // [R8]
      else $error("port decode wrong");
   pin_dec_a: assert property (s_q.mux_en && s_q.prt == 2'h3 && s_q.pin == 3'h4 // [R9]
      |-> pin_sel == 32'h1000_0000)
      else $error("pin decode wrong");
   gain_dec_a: assert property (s_q.gain[2] |-> // [R10]
      gain_sel[s_q.gain[1] ? GAIN_HALF : GAIN_X16] && $onehot(gain_sel))
      else $error("gain decode wrong");
   gain_range_a: assert property (!s_q.gain[2] |-> gain_sel == 6'(2) << s_q.gain[1:0]) // [R5]
      else $error("gain select wrong");
   gain_reset_a: assert property (!cfg_written_q |-> gain_sel == 6'h02) // [R6]
      else $error("gain not unity after reset");
   conv_result_a: assert property (conv_end_s |-> s_q.int_flag && // [R1]
      s_q.data == $past(s_q.res_s2))
      else $error("conversion end did not latch result");
   off_frozen_a: assert property (!s_q.en && !ctrl_wr |=> // [R11]
      $stable(conv_busy) && $stable(s_q.int_flag))
      else $error("status changed while disabled");
   start_sw_a: assert property (s_q.en && !conv_busy && sw_start && s_q.stm == STM_SW // [R2]
      |=> conv_busy ##1 conv_busy)
      else $error("software start not taken");

endmodule

/* File: verif/test_adc_input_select_gain_control.sv */
`timescale 1ns/1ps
module test_adc_input_select_gain_control;
   import adcsel_pkg::*;
   // ==========================================================
   // bench signals and model state
   logic            clock;
   logic            arst_n;
   logic            hsel;
   logic [31:0]     haddr;
   logic [1:0]      htrans;
   logic            hwrite;
   logic [2:0]      hsize;
   logic [31:0]     hwdata;
   adcsel_ahb_req_s ahb_req;
   adcsel_ahb_rsp_s ahb_rsp;
   logic            timer_ovf;
   logic [7:0]      sar_result;
   logic            analog_en;
   logic            conv_busy;
   logic [31:0]     pin_sel;
   logic [5:0]      gain_sel;
   int              err_total;
   int              tests_run;
   int              cycles;
   int              n;
   int              gain_line [8] = '{1, 2, 3, 4, 5, 5, 0, 0};
   logic [7:0]      sar_q [$];
   logic [31:0]     v;
   // single slave, so its hreadyout is the bus hready
   assign ahb_req = '{hsel, haddr, htrans, hwrite, hsize, hwdata, ahb_rsp.hreadyout};
   adcsel_top DUT (
      .clock      (clock),
      .arst_n     (arst_n),
      .ahb_req    (ahb_req),
      .ahb_rsp    (ahb_rsp),
      .timer_ovf  (timer_ovf),
      .sar_result (sar_result),
      .analog_en  (analog_en),
      .conv_busy  (conv_busy),
      .pin_sel    (pin_sel),
      .gain_sel   (gain_sel)
   );
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   // ==========================================================
   // comparisons and verdict
   task automatic report(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
      report(got, exp);
   endtask
   task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
      report(got, exp);
   endtask
   task automatic chk_gain(input logic [5:0] got, input logic [5:0] exp);
      report({26'h0, got}, {26'h0, exp});
   endtask
   task automatic chk_flag(input logic got, input logic exp);
      report({31'h0, got}, {31'h0, exp});
   endtask
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // ==========================================================
   // bus master: entered just after a rising edge
   task automatic bus(input logic [11:0] a, input logic wr, input logic [31:0] d,
                      output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= 3'h2;
      @(posedge clock);
      while (ahb_rsp.hreadyout !== 1'b1) @(posedge clock);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clock);
      while (ahb_rsp.hreadyout !== 1'b1) @(posedge clock);
      q = ahb_rsp.hrdata;
   endtask
   // one extra edge so outputs are sampled settled
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(a, 1'b1, d, q);
      @(posedge clock);
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(a, 1'b0, 32'h0, q);
      chk_rd(q, exp);
      chk_flag(ahb_rsp.hresp, 1'b0);
   endtask
   // ==========================================================
   // timeout
   initial begin
      cycles = 0;
      forever begin
         @(posedge clock);
         cycles++;
         if (cycles > 5000) begin
            err_total++;
            end_of_test();
         end
      end
   end
   // ==========================================================
   // main sequence
   initial begin
      err_total = 0;
      tests_run = 0;
      arst_n = 1'b0;
      {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
      timer_ovf = 1'b0;
      sar_result = 8'h00;
      void'($urandom(33072));
      repeat (3) @(posedge clock);
      arst_n <= 1'b1;
      @(posedge clock);
      chk_gain(gain_sel, 6'h02);
      chk_pin(pin_sel, 32'h0);
      chk_flag(analog_en, 1'b0);
      rd_chk(CFG_ADDR, {24'h0, CFG_RST});
      for (int i = 0; i < 32; i++) begin
         v = ($urandom() & 32'hffffffc0) | 32'h20 | i;
         wr(SEL_ADDR, v);
         chk_pin(pin_sel, 32'h1 << (v[4:3] * 8 + v[2:0]));
         rd_chk(SEL_ADDR, v & 32'h3f);
      end
      wr(SEL_ADDR, 32'h1f);
      chk_pin(pin_sel, 32'h0);
      for (int g = 0; g < 8; g++) begin
         wr(CFG_ADDR, ($urandom() & 32'hffffff18) | g);
         chk_gain(gain_sel, 6'h1 << gain_line[g]);
         rd_chk(CFG_ADDR, g);
      end
      // starts while disabled, by write and by timer, must be dropped
      wr(CTRL_ADDR, 32'h10);
      chk_flag(conv_busy, 1'b0);
      wr(CTRL_ADDR, 32'h0c);
      timer_ovf <= 1'b1;
      @(posedge clock);
      timer_ovf <= 1'b0;
      repeat (3) @(posedge clock);
      chk_flag(conv_busy, 1'b0);
      chk_flag(analog_en, 1'b0);
      for (int m = 0; m < 2; m++) begin
         v = $urandom();
         sar_result <= v[7:0];
         sar_q.push_back(v[7:0]);
         wr(CTRL_ADDR, 32'h80 | (m == 0 ? 32'h00 : 32'h0c));
         chk_flag(analog_en, 1'b1);
         if (m == 0) begin
            wr(CTRL_ADDR, 32'h90);
         end else begin
            timer_ovf <= 1'b1;
            @(posedge clock);
            timer_ovf <= 1'b0;
            @(posedge clock);
         end
         chk_flag(conv_busy, 1'b1);
         n = 0;
         while (conv_busy === 1'b1 && n < 200) begin
            @(posedge clock);
            n++;
         end
         chk_flag(conv_busy, 1'b0);
         rd_chk(DATA_ADDR, {24'h0, sar_q.pop_front()});
         rd_chk(CTRL_ADDR, 32'ha0 | (m == 0 ? 32'h0 : 32'h0c));
      end
      // disable in mid-conversion: busy flag must freeze
      // start mode is taken from the value held before the write, so set 00 first
      wr(CTRL_ADDR, 32'h80);
      wr(CTRL_ADDR, 32'h90);
      wr(CTRL_ADDR, 32'h00);
      chk_flag(analog_en, 1'b0);
      repeat (20) @(posedge clock);
      chk_flag(conv_busy, 1'b1);
      rd_chk(CTRL_ADDR, 32'h10);
      wr(12'h004, 32'hffffffff);
      rd_chk(12'h004, 32'h0);
      // reset in mid-run: frozen conversion dropped, gain back to unity
      arst_n <= 1'b0;
      repeat (2) @(posedge clock);
      arst_n <= 1'b1;
      @(posedge clock);
      chk_gain(gain_sel, 6'h02);
      chk_flag(conv_busy, 1'b0);
      chk_pin(pin_sel, 32'h0);
      rd_chk(CFG_ADDR, {24'h0, CFG_RST});
      end_of_test();
   end
endmodule
